// [rtl/lst_fifo.sv]
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none
module lst_fifo #(
	parameter int WIDTH = lst_pkg::WORD_WIDTH,
	parameter int DEPTH = lst_pkg::FIFO_DEPTH
) (
	input  wire logic clock,
	input  wire logic rst,
	lst_fifo_if.fifo  port
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             do_push;
	logic             do_pop;

	// ------------------------------------------------------------------
	// Handshakes
	// ------------------------------------------------------------------
	assign port.push_ready = (count != (AW+1)'(DEPTH));
	assign port.pop_valid  = (count != '0);
	assign port.pop_data   = store[rd_ptr];
	assign port.level      = 3'(count);
	assign do_push         = port.push_valid && port.push_ready;
	assign do_pop          = port.pop_valid && port.pop_ready;

	// Storage write; no reset needed for the array itself
	always_ff @(posedge clock) begin
		if (do_push) begin
			store[wr_ptr] <= port.push_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge clock) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (do_push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
			end
			if (do_pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
			end
			count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end
endmodule : lst_fifo
`default_nettype wire

// [rtl/lst_fifo_if.sv]
/*
 * Word stream carrier between the register slave and the word FIFO.
 * Assumes both ends share one clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface lst_fifo_if;
	logic [lst_pkg::WORD_WIDTH-1:0] push_data;
	logic                           push_valid;
	logic                           push_ready;
	logic [lst_pkg::WORD_WIDTH-1:0] pop_data;
	logic                           pop_valid;
	logic                           pop_ready;
	logic [2:0]                     level;
	modport fifo (input push_data, input push_valid, output push_ready,
		output pop_data, output pop_valid, input pop_ready, output level);
	modport user (output push_data, output push_valid, input push_ready,
		input pop_data, input pop_valid, output pop_ready, input level);
endinterface : lst_fifo_if
`default_nettype wire

// [rtl/lst_pkg.sv]
/*
 * Constants shared by the serializer transmitter and its word FIFO.
 * Assumes a single 40 MHz clock that serves as the fast serial clock.
 */
package lst_pkg;
	// ------------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------------
	localparam int LANE_COUNT  = 4;
	localparam int SER_FACTOR  = 7;
	localparam int WORD_WIDTH  = LANE_COUNT * SER_FACTOR;
	localparam int FIFO_DEPTH  = 4;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLOCK_PERIOD_PS  = 25000;
	localparam int REF_PERIOD_PS    = CLOCK_PERIOD_PS * SER_FACTOR;
	localparam int OUT_DATA_RATE_PS = CLOCK_PERIOD_PS;
	localparam int PLL_RATIO        = REF_PERIOD_PS / OUT_DATA_RATE_PS;
	localparam int LOCK_TIME_NS     = 1000;
	localparam int LOCK_CYCLES      = (LOCK_TIME_NS * 1000) / CLOCK_PERIOD_PS;
	localparam int PLL_RST_NS       = 100;
	localparam int PLL_RST_CYCLES   = (PLL_RST_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] CTRL_OFFSET   = 8'h00;
	localparam logic [7:0] CLKCFG_OFFSET = 8'h04;
	localparam logic [7:0] STATUS_OFFSET = 8'h08;
	localparam logic [7:0] DATA_OFFSET   = 8'h0c;

	// ------------------------------------------------------------------
	// Control fields
	// ------------------------------------------------------------------
	localparam int CTRL_ENABLE_BIT   = 0;
	localparam int CTRL_SELFRST_BIT  = 1;
	localparam int CTRL_EXTPLL_BIT   = 2;
	localparam int CTRL_NOSHIFT_BIT  = 3;
	localparam int CTRL_INREG_LSB    = 4;
	localparam int CTRL_INALIGN_LSB  = 6;
	localparam int CTRL_OUTALIGN_LSB = 9;
	localparam int CTRL_PLLRST_BIT   = 12;

	// Clock configuration fields
	localparam int CLK_DIV_LSB    = 0;
	localparam int CLK_MULT_LSB   = 5;
	localparam int CLK_DUTY50_BIT = 7;
	localparam int CLK_HIGH_LSB   = 8;
	localparam int CLK_PHASE_LSB  = 13;

	// Status fields
	localparam int ST_LOCKED_BIT   = 0;
	localparam int ST_RUNNING_BIT  = 1;
	localparam int ST_NODUTY_BIT   = 2;
	localparam int ST_UNDERRUN_BIT = 3;
	localparam int ST_LEVEL_LSB    = 4;
	localparam int ST_RATIO_LSB    = 8;
	localparam int ST_QUARTER_LSB  = 12;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [4:0]  DIV_RESET     = 5'h07;
	localparam logic [1:0]  MULT_RESET    = 2'h1;
	localparam logic [4:0]  HIGH_RESET    = 5'h01;
	localparam logic [18:0] PHASE_RESET   = 19'h00000;
	localparam logic [2:0]  ALIGN_RESET   = 3'h0;

	// Input registering modes
	typedef enum logic [1:0] {
		LST_INREG_ON   = 2'b00,
		LST_INREG_OFF  = 2'b01,
		LST_INREG_REF  = 2'b10,
		LST_INREG_CORE = 2'b11
	} lst_inreg_type;
endpackage : lst_pkg

// [rtl/lst_transmitter.sv]
/*
 * Multi-lane serializer transmitter with forwarded clock and APB registers.
 * Assumes clock is the fast serial clock; the core word rate is one word
 * every SER_FACTOR clocks. An external clock generator may supply lock.
 */
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module lst_transmitter (
	input  wire logic                                clock,
	input  wire logic                                rst,
	input  wire logic                                psel,
	input  wire logic                                penable,
	input  wire logic                                pwrite,
	input  wire logic [7:0]                          paddr,
	input  wire logic [31:0]                         pwdata,
	output logic                                     pready,
	output logic [31:0]                              prdata,
	output logic                                     pslverr,
	input  wire logic                                ext_pll_locked,
	output logic                                     pll_reset,
	output logic [lst_pkg::LANE_COUNT-1:0]           tx_serial,
	output logic                                     tx_fwd_clock
);
	localparam int F = lst_pkg::SER_FACTOR;

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	lst_fifo_if fifo_bus ();

	logic        enable;
	logic        self_reset_en;
	logic        use_ext_pll;
	logic        no_phase_shift;
	lst_pkg::lst_inreg_type inreg_mode;
	logic [2:0]  in_align;
	logic [2:0]  out_align;
	logic        pll_reset_req;
	logic [4:0]  fwd_clock_divider;
	logic [1:0]  fwd_clock_multiplier;
	logic        duty50;
	logic [4:0]  duty_high;
	logic [18:0] phase_ps;
	logic        underrun;
	logic        ext_lock_meta;
	logic        ext_lock_sync;
	logic [6:0]  lock_count;
	logic        int_locked;
	logic        locked;
	logic        locked_prev;
	logic [2:0]  self_rst_count;
	logic        running;
	logic [2:0]  bit_count;
	logic        word_edge;
	logic [lst_pkg::WORD_WIDTH-1:0] stage;
	logic        stage_valid;
	logic [lst_pkg::WORD_WIDTH-1:0] next_word;
	logic        next_word_valid;
	logic [4:0]  fwd_period;
	logic [4:0]  fwd_high;
	logic [4:0]  fwd_count;
	logic [4:0]  fwd_offset;
	logic [1:0]  phase_quarter;
	logic        duty_refused;
	logic        access;
	logic        wr_ok;
	logic        data_wr;
	logic        mapped;

	// ------------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------------
	assign access   = psel && penable;
	assign mapped   = (paddr == lst_pkg::CTRL_OFFSET) || (paddr == lst_pkg::CLKCFG_OFFSET)
		|| (paddr == lst_pkg::STATUS_OFFSET) || (paddr == lst_pkg::DATA_OFFSET);
	assign data_wr  = access && pwrite && (paddr == lst_pkg::DATA_OFFSET);
	// A data write waits while the FIFO is full, so back-pressure reaches software
	assign pready   = !(data_wr && !fifo_bus.push_ready);
	assign pslverr  = access && !mapped;
	assign wr_ok    = access && pwrite && pready;

	assign fifo_bus.push_data  = pwdata[lst_pkg::WORD_WIDTH-1:0];
	assign fifo_bus.push_valid = data_wr;

	// Control register
	always_ff @(posedge clock) begin
		if (rst) begin
			enable         <= 1'b0;
			self_reset_en  <= 1'b0;
			use_ext_pll    <= 1'b0;
			no_phase_shift <= 1'b1;
			inreg_mode     <= lst_pkg::LST_INREG_CORE;
			in_align       <= lst_pkg::ALIGN_RESET;
			out_align      <= lst_pkg::ALIGN_RESET;
			pll_reset_req  <= 1'b0;
		end else if (wr_ok && paddr == lst_pkg::CTRL_OFFSET) begin
			enable         <= pwdata[lst_pkg::CTRL_ENABLE_BIT];
			self_reset_en  <= pwdata[lst_pkg::CTRL_SELFRST_BIT];
			use_ext_pll    <= pwdata[lst_pkg::CTRL_EXTPLL_BIT];
			no_phase_shift <= pwdata[lst_pkg::CTRL_NOSHIFT_BIT];
			inreg_mode     <= lst_pkg::lst_inreg_type'(pwdata[lst_pkg::CTRL_INREG_LSB +: 2]);
			in_align       <= pwdata[lst_pkg::CTRL_INALIGN_LSB +: 3];
			out_align      <= pwdata[lst_pkg::CTRL_OUTALIGN_LSB +: 3];
			pll_reset_req  <= pwdata[lst_pkg::CTRL_PLLRST_BIT];
		end
	end

	// Clock configuration register
	always_ff @(posedge clock) begin
		if (rst) begin
			fwd_clock_divider    <= lst_pkg::DIV_RESET;
			fwd_clock_multiplier <= lst_pkg::MULT_RESET;
			duty50               <= 1'b1;
			duty_high            <= lst_pkg::HIGH_RESET;
			phase_ps             <= lst_pkg::PHASE_RESET;
		end else if (wr_ok && paddr == lst_pkg::CLKCFG_OFFSET) begin
			// A divider of zero would stall the counter; keep the old value
			if (pwdata[lst_pkg::CLK_DIV_LSB +: 5] != 5'h00) begin
				fwd_clock_divider <= pwdata[lst_pkg::CLK_DIV_LSB +: 5];
			end
			// Only one and two are legal multipliers; others leave it unchanged
			if (pwdata[lst_pkg::CLK_MULT_LSB +: 2] == 2'h1
				|| pwdata[lst_pkg::CLK_MULT_LSB +: 2] == 2'h2) begin
				fwd_clock_multiplier <= pwdata[lst_pkg::CLK_MULT_LSB +: 2];
			end
			duty50    <= pwdata[lst_pkg::CLK_DUTY50_BIT];
			duty_high <= pwdata[lst_pkg::CLK_HIGH_LSB +: 5];
			phase_ps  <= pwdata[lst_pkg::CLK_PHASE_LSB +: 19];
		end
	end

	// Underrun flag: a new underrun in the clearing cycle wins
	always_ff @(posedge clock) begin
		if (rst) begin
			underrun <= 1'b0;
		end else if (running && word_edge && !next_word_valid) begin
			underrun <= 1'b1;
		end else if (wr_ok && paddr == lst_pkg::STATUS_OFFSET
			&& pwdata[lst_pkg::ST_UNDERRUN_BIT]) begin
			underrun <= 1'b0;
		end
	end

	// Read data register
	always_ff @(posedge clock) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= 32'h0000_0000;
			unique case (paddr)
				lst_pkg::CTRL_OFFSET: begin
					prdata[lst_pkg::CTRL_ENABLE_BIT]       <= enable;
					prdata[lst_pkg::CTRL_SELFRST_BIT]      <= self_reset_en;
					prdata[lst_pkg::CTRL_EXTPLL_BIT]       <= use_ext_pll;
					prdata[lst_pkg::CTRL_NOSHIFT_BIT]      <= no_phase_shift;
					prdata[lst_pkg::CTRL_INREG_LSB +: 2]   <= inreg_mode;
					prdata[lst_pkg::CTRL_INALIGN_LSB +: 3] <= in_align;
					prdata[lst_pkg::CTRL_OUTALIGN_LSB +: 3] <= out_align;
					prdata[lst_pkg::CTRL_PLLRST_BIT]       <= pll_reset_req;
				end
				lst_pkg::CLKCFG_OFFSET: begin
					prdata[lst_pkg::CLK_DIV_LSB +: 5]   <= fwd_clock_divider;
					prdata[lst_pkg::CLK_MULT_LSB +: 2]  <= fwd_clock_multiplier;
					prdata[lst_pkg::CLK_DUTY50_BIT]     <= duty50;
					prdata[lst_pkg::CLK_HIGH_LSB +: 5]  <= duty_high;
					prdata[lst_pkg::CLK_PHASE_LSB +: 19] <= phase_ps;
				end
				lst_pkg::STATUS_OFFSET: begin
					prdata[lst_pkg::ST_LOCKED_BIT]      <= locked;
					prdata[lst_pkg::ST_RUNNING_BIT]     <= running;
					prdata[lst_pkg::ST_NODUTY_BIT]      <= duty_refused;
					prdata[lst_pkg::ST_UNDERRUN_BIT]    <= underrun;
					prdata[lst_pkg::ST_LEVEL_LSB +: 3]  <= fifo_bus.level;
					prdata[lst_pkg::ST_RATIO_LSB +: 4]  <= 4'(lst_pkg::PLL_RATIO);
					prdata[lst_pkg::ST_QUARTER_LSB +: 2] <= phase_quarter;
				end
				default: begin
					prdata <= 32'h0000_0000;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Clock generator lock and self reset
	// ------------------------------------------------------------------
	// External lock is asynchronous to us: two flops before any use
	always_ff @(posedge clock) begin
		if (rst) begin
			ext_lock_meta <= 1'b0;
			ext_lock_sync <= 1'b0;
		end else begin
			ext_lock_meta <= ext_pll_locked;
			ext_lock_sync <= ext_lock_meta;
		end
	end

	// Internal generator model: locks a fixed time after its reset ends
	always_ff @(posedge clock) begin
		if (rst || pll_reset) begin
			lock_count <= 7'h00;
			int_locked <= 1'b0;
		end else if (lock_count == 7'(lst_pkg::LOCK_CYCLES - 1)) begin
			int_locked <= 1'b1;
		end else begin
			lock_count <= lock_count + 7'h01;
		end
	end

	assign locked = use_ext_pll ? ext_lock_sync : int_locked;

	// Self reset pulse when lock falls away
	always_ff @(posedge clock) begin
		if (rst) begin
			locked_prev    <= 1'b0;
			self_rst_count <= 3'h0;
		end else begin
			locked_prev <= locked;
			if (self_reset_en && locked_prev && !locked) begin
				self_rst_count <= 3'(lst_pkg::PLL_RST_CYCLES);
			end else if (self_rst_count != 3'h0) begin
				self_rst_count <= self_rst_count - 3'h1;
			end
		end
	end

	// Reset drive to whichever generator is in use
	always_ff @(posedge clock) begin
		if (rst) begin
			pll_reset <= 1'b1;
		end else begin
			pll_reset <= pll_reset_req || (self_rst_count != 3'h0);
		end
	end

	// ------------------------------------------------------------------
	// Word timing and input staging
	// ------------------------------------------------------------------
	// Start on the first edge that sees lock, stop when lock is lost
	always_ff @(posedge clock) begin
		if (rst) begin
			running <= 1'b0;
		end else begin
			running <= enable && locked;
		end
	end

	assign word_edge = (bit_count == 3'(F - 1));

	// Bit position inside the current word
	always_ff @(posedge clock) begin
		if (rst || !running) begin
			bit_count <= 3'(F - 1);
		end else begin
			bit_count <= word_edge ? 3'h0 : bit_count + 3'h1;
		end
	end

	// Registering off takes the FIFO head straight at the word boundary;
	// the registered modes hold one extra word in the staging register
	always_comb begin
		if (inreg_mode == lst_pkg::LST_INREG_OFF) begin
			next_word       = fifo_bus.pop_data;
			next_word_valid = fifo_bus.pop_valid;
		end else begin
			next_word       = stage;
			next_word_valid = stage_valid;
		end
	end

	assign fifo_bus.pop_ready = (inreg_mode == lst_pkg::LST_INREG_OFF)
		? (running && word_edge)
		: (!stage_valid || (running && word_edge));

	// Staging register, used when input registering is on
	always_ff @(posedge clock) begin
		if (rst || inreg_mode == lst_pkg::LST_INREG_OFF) begin
			stage       <= '0;
			stage_valid <= 1'b0;
		end else if (fifo_bus.pop_ready) begin
			stage       <= fifo_bus.pop_data;
			stage_valid <= fifo_bus.pop_valid;
		end
	end

	// ------------------------------------------------------------------
	// Lane shifters
	// ------------------------------------------------------------------
	generate
		for (genvar l = 0; l < lst_pkg::LANE_COUNT; l++) begin : g_lane
			logic [F-1:0] shift;
			// Each lane loads its own slice and sends it MSB first
			always_ff @(posedge clock) begin
				if (rst || !running) begin
					shift <= '0;
				end else if (word_edge) begin
					// Idle zeros are sent when no word is ready
					shift <= next_word_valid ? next_word[l*F +: F] : '0;
				end else begin
					shift <= {shift[F-2:0], 1'b0};
				end
			end
			assign tx_serial[l] = shift[F-1];
		end
	endgenerate

	// ------------------------------------------------------------------
	// Forwarded clock
	// ------------------------------------------------------------------
	assign duty_refused = (F % 2 == 1) && (fwd_clock_divider == 5'(F))
		&& (fwd_clock_multiplier == 2'h2);

	// Period in bit times; a multiplier of two halves it
	always_comb begin
		fwd_period = (fwd_clock_multiplier == 2'h2) ? (fwd_clock_divider >> 1) : fwd_clock_divider;
		if (fwd_period == 5'h00) begin
			fwd_period = 5'h01;
		end
		// An odd period cannot be split evenly, so the high time rounds down
		if (duty50) begin
			fwd_high = fwd_period >> 1;
		end else begin
			fwd_high = (duty_high >= fwd_period) ? fwd_period - 5'h01 : duty_high;
		end
		if (fwd_high == 5'h00) begin
			fwd_high = 5'h01;
		end
	end

	// Phase shift folded into one reference period and snapped to quarters
	assign phase_quarter = 2'(((32'(phase_ps) % lst_pkg::REF_PERIOD_PS) * 4
		+ lst_pkg::REF_PERIOD_PS / 2) / lst_pkg::REF_PERIOD_PS);

	// Start offset from alignment code, centring shift and phase shift
	always_comb begin
		logic [9:0] sum;
		sum = 10'((32'(out_align) * 32'(fwd_period)) >> 3);
		if (!no_phase_shift) begin
			sum = sum + 10'(fwd_period >> 2);
		end
		sum = sum + 10'((32'(phase_quarter) * 32'(fwd_period)) >> 2);
		for (int i = 0; i < 3; i++) begin
			if (sum >= 10'(fwd_period)) begin
				sum = sum - 10'(fwd_period);
			end
		end
		fwd_offset = sum[4:0];
	end

	// Phase counter; all ones marks a stopped link, so the offset applies once
	// per start and never bends the period of a running clock
	always_ff @(posedge clock) begin
		if (rst || !running) begin
			fwd_count    <= 5'h1f;
			tx_fwd_clock <= 1'b0;
		end else begin
			if (fwd_count == 5'h1f) begin
				fwd_count <= (fwd_offset >= fwd_period - 5'h01) ? 5'h00 : fwd_offset + 5'h01;
			end else begin
				fwd_count <= (fwd_count >= fwd_period - 5'h01) ? 5'h00 : fwd_count + 5'h01;
			end
			tx_fwd_clock <= (((fwd_count == 5'h1f) ? fwd_offset : fwd_count) < fwd_high);
		end
	end

	// ------------------------------------------------------------------
	// Word FIFO
	// ------------------------------------------------------------------
	lst_fifo #(
		.WIDTH (lst_pkg::WORD_WIDTH),
		.DEPTH (lst_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock (clock),
		.rst   (rst),
		.port  (fifo_bus.fifo)
	);
endmodule : lst_transmitter
`default_nettype wire

// [tb/lst_link_receiver.sv]
/* Far-end receiver model: rebuilds words from the lanes, times the clock.
   Assumes each word has lane 0 high first and words follow back to back. */
`timescale 1ns/10ps
`default_nettype none
module lst_link_receiver (
	input wire logic                           clock,
	input wire logic                           rst,
	input wire logic [lst_pkg::LANE_COUNT-1:0] tx_serial,
	input wire logic                           tx_fwd_clock,
	output logic [lst_pkg::WORD_WIDTH-1:0]     word_out,
	output logic                               word_strobe,
	output logic [7:0]                         period
);
	logic [lst_pkg::LANE_COUNT-1:0][lst_pkg::SER_FACTOR-1:0] lanes;
	logic       active;
	logic       last_fwd;
	logic [7:0] since;
	int         bits;
	// Start on the first high bit; zeros before it are underrun fill
	always @(posedge clock) begin
		word_strobe <= 1'b0;
		if (rst) begin
			active = 1'b0;
			bits = 0;
		end else if (active || tx_serial[0]) begin
			active = 1'b1;
			for (int j = 0; j < lst_pkg::LANE_COUNT; j++)
				lanes[j] = {lanes[j][lst_pkg::SER_FACTOR-2:0], tx_serial[j]};
			bits++;
			if (bits == lst_pkg::SER_FACTOR) begin
				word_out <= lanes;
				word_strobe <= 1'b1;
				bits = 0;
			end
		end
	end
	// Bit times between rising edges of the forwarded clock
	always @(posedge clock) begin
		last_fwd <= tx_fwd_clock;
		since <= (tx_fwd_clock && !last_fwd) ? 8'h01 : since + 8'h01;
		if (tx_fwd_clock && !last_fwd)
			period <= since;
	end
endmodule : lst_link_receiver
`default_nettype wire

// [tb/lst_transmitter_properties.sv]
/* Port checker for the serializer transmitter: APB answers, reset, idle lanes.
   Assumes binding to lst_transmitter, one clock, synchronous reset. */
`timescale 1ns/10ps
`default_nettype none
module lst_transmitter_properties (
	input wire logic                           clock,
	input wire logic                           rst,
	input wire logic                           psel,
	input wire logic                           penable,
	input wire logic                           pwrite,
	input wire logic [7:0]                     paddr,
	input wire logic [31:0]                    pwdata,
	input wire logic                           pready,
	input wire logic [31:0]                    prdata,
	input wire logic                           pslverr,
	input wire logic                           pll_reset,
	input wire logic [lst_pkg::LANE_COUNT-1:0] tx_serial,
	input wire logic                           tx_fwd_clock
);
	// ------------------------------------------------------------------
	// Decode and helper state
	// ------------------------------------------------------------------
	wire  acc    = psel && penable;
	wire  mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c};
	logic en_seen;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Lanes may only move once software has enabled them
	always_ff @(posedge clock) begin
		if (rst)
			en_seen <= 1'b0;
		else if (acc && pready && pwrite && paddr == 8'h00 && pwdata[0])
			en_seen <= 1'b1;
	end
	err_in_access_a: assert property (pslverr |-> acc)
		else $error("error flag outside access phase");
	unmapped_err_a: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (acc && mapped |-> !pslverr)
		else $error("mapped access refused");
	stall_data_a: assert property (!pready |-> acc && pwrite && paddr == 8'h0c)
		else $error("wait state outside data push");
	reset_out_a: assert property ($past(rst) |-> pll_reset && pready && prdata == 32'h0
		&& tx_serial == '0 && !tx_fwd_clock) else $error("outputs wrong after reset");
	pll_release_a: assert property ($fell(rst) |-> ##[0:2] !pll_reset)
		else $error("generator reset not released");
	idle_quiet_a: assert property (!en_seen |-> !tx_fwd_clock && tx_serial == '0)
		else $error("lanes active before enable");
	read_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data moved outside read setup");
endmodule : lst_transmitter_properties
`default_nettype wire

// [tb/lst_transmitter_test.sv]
/* Self-checking bench: register rows, then reset, traffic, divider and lock loss.
   Assumes the transmitter, its package and the receiver model are compiled. */
`timescale 1ns/10ps
`default_nettype none
module lst_transmitter_test;
	typedef struct {logic [7:0] addr; logic [31:0] wdata; logic [7:0] raddr;
		logic [31:0] mask; logic [31:0] exp;} lst_row_type;
	logic clock, rst, psel, penable, pwrite, pready, pslverr, ext_pll_locked;
	logic pll_reset, tx_fwd_clock, strobe, err, seen;
	logic [7:0]                         paddr, period;
	logic [31:0]                        pwdata, prdata, rd, w;
	logic [lst_pkg::LANE_COUNT-1:0]     tx_serial;
	logic [lst_pkg::WORD_WIDTH-1:0]     word, exp_w[6], got_q[$];
	lst_row_type                        rows[18];
	int                                 n_errors = 0, check_count = 0, cycles = 0;
	lst_transmitter uut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.prdata, .pslverr, .ext_pll_locked, .pll_reset, .tx_serial, .tx_fwd_clock);
	lst_link_receiver far (.clock, .rst, .tx_serial, .tx_fwd_clock, .word_out(word),
		.word_strobe(strobe), .period);
	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Request held until pready is sampled high; only the hang guard ends a wait
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge clock);
	endtask : apb
	task automatic summarize();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			summarize();
		end
	end
	always @(posedge clock) if (strobe === 1'b1) got_q.push_back(word);
	initial begin
		rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
		pwdata = 32'h0; ext_pll_locked = 1'b1;
		// Control codes: all alignments and registering modes
		for (int i = 0; i < 8; i++) begin
			w = {20'h0, 3'(i), ~3'(i), 2'(i), 1'(i), 3'h0};
			rows[i] = '{8'h00, w, 8'h00, 32'hff8, w};
		end
		rows[8]  = '{8'h04, 32'h1e7, 8'h04, 32'h60, 32'h20};
		rows[9]  = '{8'h04, 32'h1c7, 8'h08, 32'h4, 32'h4};
		rows[10] = '{8'h04, 32'h1c0, 8'h04, 32'h1f, 32'h07};
		rows[11] = '{8'h04, 32'h1a5, 8'h08, 32'h4, 32'h0};
		rows[12] = '{8'h04, {19'h00000, 13'h1a7}, 8'h08, 32'h3f00, 32'h700};
		rows[13] = '{8'h04, {19'h0aae6, 13'h1a7}, 8'h08, 32'h3000, 32'h1000};
		rows[14] = '{8'h04, {19'h155cc, 13'h1a7}, 8'h08, 32'h3000, 32'h2000};
		rows[15] = '{8'h04, {19'h200b2, 13'h1a7}, 8'h08, 32'h3000, 32'h3000};
		rows[16] = '{8'h04, {19'h3567e, 13'h1a7}, 8'h08, 32'h3000, 32'h1000};
		rows[17] = '{8'h04, {19'h0c350, 13'h1a7}, 8'h08, 32'h3000, 32'h1000};
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		foreach (rows[i]) begin
			apb(1'b1, rows[i].addr, rows[i].wdata, rd, err);
			apb(1'b0, rows[i].raddr, 32'h0, rd, err);
			chk(rd & rows[i].mask, rows[i].exp);
		end
		// Second reset in mid-run, then reset values
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		apb(1'b0, 8'h00, 32'h0, rd, err);
		chk(rd, 32'h38);
		apb(1'b0, 8'h04, 32'h0, rd, err);
		chk(rd, 32'h1a7);
		apb(1'b0, 8'h10, 32'h0, rd, err);
		chk({rd[31:1], err}, 32'h1);
		// Internal generator: enable and wait for lock and running
		apb(1'b1, 8'h00, 32'h39, rd, err);
		for (int n = 0; n < 20 && rd[1] !== 1'b1; n++)
			apb(1'b0, 8'h08, 32'h0, rd, err);
		chk(rd & 32'h3, 32'h3);
		// Six words against a four-word buffer: lanes drain it as it fills, so no push stalls
		for (int i = 0; i < 6; i++) begin
			w = {4'hf, 7'h40 + 7'(i), 7'h41, 7'h22 + 7'(i), 7'h40 | 7'(i)};
			exp_w[i] = w[lst_pkg::WORD_WIDTH-1:0];
			apb(1'b1, 8'h0c, w, rd, err);
		end
		for (int n = 0; n < 200 && got_q.size() < 6; n++)
			@(posedge clock);
		foreach (exp_w[i])
			chk(32'(got_q[i]), 32'(exp_w[i]));
		apb(1'b0, 8'h08, 32'h0, rd, err);
		chk(rd & 32'h8, 32'h8);
		chk(32'(period), 32'h7);
		apb(1'b1, 8'h04, 32'h1a5, rd, err);
		repeat (30) @(posedge clock);
		chk(32'(period), 32'h5);
		apb(1'b1, 8'h04, 32'h1c7, rd, err);
		repeat (30) @(posedge clock);
		chk(32'(period), 32'h3);
		// External generator with self-reset; lock drops
		apb(1'b1, 8'h00, 32'h3f, rd, err);
		ext_pll_locked <= 1'b0;
		seen = 1'b0;
		repeat (12) begin
			@(posedge clock);
			if (pll_reset === 1'b1)
				seen = 1'b1;
		end
		chk({31'h0, seen}, 32'h1);
		apb(1'b0, 8'h08, 32'h0, rd, err);
		chk(rd & 32'h1, 32'h0);
		summarize();
	end
endmodule : lst_transmitter_test
bind lst_transmitter lst_transmitter_properties props (.clock, .rst, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .pll_reset, .tx_serial,
	.tx_fwd_clock);
`default_nettype wire
